// >>> logic/cmr_readout.sv
// Calibration memory store, readout stream and output selection
//
// What this block does
// - Read command streams whole memory as bytes
// - Shift image eight bits after each byte
// - Bytes 1-11 carry coefficients, low bits first
// - Bytes 12-19 ID, signature, trims; 20 is A5
// - Output select picks bridge or bridge+temperature
// - Lock codes 6/3 block writes until unlock
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module cmr_readout
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [4:0]  addr_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        wr_stb_in,
  input  wire logic        rd_stb_in,
  output logic      [7:0]  rd_data_out,
  input  wire logic        cmd_valid_in,
  input  wire logic [15:0] cmd_code_in,
  output logic             tx_valid_out,
  output logic      [7:0]  tx_byte_out,
  input  wire logic        tx_ready_in,
  input  wire logic        meas_stb_in,
  input  wire logic [13:0] bridge_meas_in,
  input  wire logic [13:0] temp_meas_in,
  output logic             meas_valid_out,
  output logic             meas_with_temp_out,
  output logic      [13:0] meas_bridge_out,
  output logic      [13:0] meas_temp_out
);
  // ****************************************
  // Memory store
  // ****************************************
  logic [7:0]                      mem_reg [0:cmr_pkg::MEM_BYTES-1];
  logic [cmr_pkg::IMAGE_BITS-1:0]  image;
  logic [2:0]                      lock_field;
  logic                            locked;
  logic                            unlock_reg;
  logic                            addr_mem;
  logic                            wr_ok;
  logic [1:0]                      out_select;

  assign lock_field = {mem_reg[cmr_pkg::LOCK_HI_BYTE][1:0],
                       mem_reg[cmr_pkg::LOCK_LO_BYTE][cmr_pkg::LOCK_LO_BIT]};
  assign locked     = (lock_field == cmr_pkg::LOCK_CODE_A) ||
                      (lock_field == cmr_pkg::LOCK_CODE_B);
  assign addr_mem   = (addr_in < 5'(cmr_pkg::MEM_BYTES));
  assign wr_ok      = wr_stb_in && addr_mem && !(locked && !unlock_reg);
  assign out_select = mem_reg[cmr_pkg::OSEL_BYTE][cmr_pkg::OSEL_LSB +: 2];
  assign image[cmr_pkg::IMAGE_BITS-1 -: 8] = cmr_pkg::TRAILER_BYTE;

  genvar gi;
  generate
    for (gi = 0; gi < cmr_pkg::MEM_BYTES; gi++)
    begin : g_mem
      always_ff @(posedge clk_in or posedge reset_in)
      begin
        if (reset_in)
        begin
          mem_reg[gi] <= cmr_pkg::MEM_RESET;
        end
        else if (wr_ok && (addr_in == 5'(gi)))
        begin
          mem_reg[gi] <= wr_data_in;
        end
      end
      assign image[8*gi +: 8] = mem_reg[gi];
    end
  endgenerate

  // Unlock holds until reset only
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      unlock_reg <= 1'b0;
    end
    else if (cmd_valid_in && (cmd_code_in == cmr_pkg::CMD_UNLOCK))
    begin
      unlock_reg <= 1'b1;
    end
  end

  // ****************************************
  // Readout stream
  // ****************************************
  logic       busy_reg;
  logic [4:0] count_reg;
  logic       start;
  logic       send;

  assign start = cmd_valid_in && (cmd_code_in == cmr_pkg::CMD_READ_MEM) && !busy_reg;
  assign send  = busy_reg && tx_ready_in;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      busy_reg  <= 1'b0;
      count_reg <= '0;
    end
    else if (start)
    begin
      busy_reg  <= 1'b1;
      count_reg <= 5'(cmr_pkg::STREAM_BYTES);
    end
    else if (send)
    begin
      count_reg <= count_reg - 5'h01;
      busy_reg  <= (count_reg != cmr_pkg::COUNT_LAST);
    end
  end

  cmr_byte_shifter u_shifter
  (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .load_in  (start),
    .image_in (image),
    .shift_in (send),
    .byte_out (tx_byte_out)
  );

  assign tx_valid_out = busy_reg;

  // ****************************************
  // Register port
  // ****************************************
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rd_data_out <= '0;
    end
    else if (rd_stb_in && addr_mem)
    begin
      rd_data_out <= mem_reg[addr_in];
    end
    else if (rd_stb_in && (addr_in == cmr_pkg::ADDR_STATUS))
    begin
      rd_data_out <= {5'h00, busy_reg, locked, unlock_reg};
    end
    else
    begin
      rd_data_out <= '0;
    end
  end

  // ****************************************
  // Digital output selection
  // ****************************************
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      meas_valid_out     <= 1'b0;
      meas_with_temp_out <= 1'b0;
      meas_bridge_out    <= '0;
      meas_temp_out      <= '0;
    end
    else
    begin
      meas_valid_out <= meas_stb_in;
      if (meas_stb_in)
      begin
        meas_with_temp_out <= (out_select != cmr_pkg::OSEL_BRIDGE);
        meas_bridge_out    <= bridge_meas_in;
        meas_temp_out      <= (out_select != cmr_pkg::OSEL_BRIDGE) ? temp_meas_in : 14'h0000;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Marks a write landing after the image was captured
  logic stream_dirty_reg;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      stream_dirty_reg <= 1'b0;
    end
    else if (start)
    begin
      stream_dirty_reg <= wr_ok;
    end
    else if (wr_ok && busy_reg)
    begin
      stream_dirty_reg <= 1'b1;
    end
  end

  logic [4:0] next_idx;
  assign next_idx = 5'(cmr_pkg::STREAM_BYTES) - count_reg + 5'h01;

  a_read_start: assert property (@(posedge clk_in) disable iff (reset_in)
    start |=> tx_valid_out && (count_reg == 5'(cmr_pkg::STREAM_BYTES)))
    else $error("read command did not start stream");

  a_first_byte: assert property (@(posedge clk_in) disable iff (reset_in)
    start |=> (tx_byte_out == $past(mem_reg[0])))
    else $error("first byte is not memory byte 1");

  a_shift_next: assert property (@(posedge clk_in) disable iff (reset_in)
    (send && (count_reg > 5'h02) && !stream_dirty_reg && !wr_ok) |=>
      (tx_byte_out == $past(mem_reg[next_idx])))
    else $error("next byte not presented after send");

  a_trailer_byte: assert property (@(posedge clk_in) disable iff (reset_in)
    (busy_reg && (count_reg == cmr_pkg::COUNT_LAST)) |-> (tx_byte_out == cmr_pkg::TRAILER_BYTE))
    else $error("last byte is not trailer");

  a_stream_ends: assert property (@(posedge clk_in) disable iff (reset_in)
    (send && (count_reg == cmr_pkg::COUNT_LAST)) |=> !tx_valid_out)
    else $error("stream did not end after twenty bytes");

  a_out_select: assert property (@(posedge clk_in) disable iff (reset_in)
    meas_stb_in |=> meas_valid_out &&
      (meas_with_temp_out == ($past(out_select) != cmr_pkg::OSEL_BRIDGE)))
    else $error("output selection not followed");

  a_lock_blocks: assert property (@(posedge clk_in) disable iff (reset_in)
    (wr_stb_in && addr_mem && locked && !unlock_reg) |=>
      (mem_reg[$past(addr_in)] == $past(mem_reg[addr_in])))
    else $error("write accepted while locked");

  a_unlock_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    unlock_reg |=> unlock_reg)
    else $error("unlock dropped before reset");

  a_unlock_set: assert property (@(posedge clk_in) disable iff (reset_in)
    (cmd_valid_in && (cmd_code_in == cmr_pkg::CMD_UNLOCK)) |=> unlock_reg)
    else $error("unlock command not taken");
endmodule
`default_nettype wire

// >>> pkg/cmr_pkg.sv
// Constants for the calibration memory readout block
package cmr_pkg;
  localparam int          MEM_BYTES     = 19;
  localparam int          STREAM_BYTES  = 20;
  localparam int          IMAGE_BITS    = 160;
  localparam logic [7:0]  TRAILER_BYTE  = 8'hA5;
  localparam logic [15:0] CMD_READ_MEM  = 16'h0000;
  localparam logic [15:0] CMD_UNLOCK    = 16'hE800;
  localparam logic [2:0]  LOCK_CODE_A   = 3'h6;
  localparam logic [2:0]  LOCK_CODE_B   = 3'h3;
  // Lock field: bit 0 in byte 9 bit 7, bits 2:1 in byte 10 bits 1:0
  localparam int          LOCK_LO_BYTE  = 8;
  localparam int          LOCK_LO_BIT   = 7;
  localparam int          LOCK_HI_BYTE  = 9;
  // Output select in byte 17 bits 4:3
  localparam int          OSEL_BYTE     = 16;
  localparam int          OSEL_LSB      = 3;
  localparam logic [1:0]  OSEL_BRIDGE   = 2'h0;
  localparam logic [4:0]  ADDR_STATUS   = 5'h13;
  localparam logic [4:0]  COUNT_LAST    = 5'h01;
  localparam logic [7:0]  MEM_RESET     = 8'h00;
endpackage

// >>> logic/cmr_byte_shifter.sv
// Image shift register presenting one byte at a time
`timescale 1ns/100ps
`default_nettype none
module cmr_byte_shifter
(
  input  wire logic                            clk_in,
  input  wire logic                            reset_in,
  input  wire logic                            load_in,
  input  wire logic [cmr_pkg::IMAGE_BITS-1:0]  image_in,
  input  wire logic                            shift_in,
  output logic      [7:0]                      byte_out
);
  logic [cmr_pkg::IMAGE_BITS-1:0] img_reg;

  // Load whole image, then drop one byte per send
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      img_reg <= '0;
    end
    else if (load_in)
    begin
      img_reg <= image_in;
    end
    else if (shift_in)
    begin
      img_reg <= {8'h00, img_reg[cmr_pkg::IMAGE_BITS-1:8]};
    end
  end

  assign byte_out = img_reg[7:0];
endmodule
`default_nettype wire

// >>> verification/cmr_host_model.sv
// Calibration host model: issues commands and collects the byte stream
`timescale 1ns/100ps
`default_nettype none
module cmr_host_model
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        start_in,
  input  wire logic [15:0] code_in,
  input  wire logic        slow_in,
  input  wire logic        tx_valid_in,
  input  wire logic [7:0]  tx_byte_in,
  output logic             cmd_valid_out,
  output logic      [15:0] cmd_code_out,
  output logic             tx_ready_out
);
  logic [7:0] rx_q[$];
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cmd_valid_out <= 1'b0;
      cmd_code_out  <= 16'h0000;
      tx_ready_out  <= 1'b0;
    end
    else
    begin
      cmd_valid_out <= start_in;
      cmd_code_out  <= code_in;
      tx_ready_out  <= slow_in ? ~tx_ready_out : 1'b1;
      if (tx_valid_in && tx_ready_out)
        rx_q.push_back(tx_byte_in);
    end
  end
endmodule
`default_nettype wire

// >>> verification/test_calibration_memory_readout.sv
// Testbench for the calibration memory readout block
`timescale 1ns/100ps
`default_nettype none
module test_calibration_memory_readout;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, ms = 0, start = 0, slow = 0;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdat = 8'h00, rdat, txb;
  logic [15:0] code = 16'h0000, cmdc;
  logic [13:0] bm = 14'h0000, tm = 14'h0000, mbo, mto;
  logic        cmdv, txv, txr, mv, mwt;
  logic [7:0]  mem[19];
  logic [2:0]  lc;
  int          num_errors = 0, num_checks = 0, cyc = 0, k, j;
  integer      seed = 32'h9E54;
  cmr_readout i_dut (.clk_in(clk), .reset_in(rst), .addr_in(addr), .wr_data_in(wdat),
    .wr_stb_in(wr), .rd_stb_in(rd), .rd_data_out(rdat), .cmd_valid_in(cmdv),
    .cmd_code_in(cmdc), .tx_valid_out(txv), .tx_byte_out(txb), .tx_ready_in(txr),
    .meas_stb_in(ms), .bridge_meas_in(bm), .temp_meas_in(tm), .meas_valid_out(mv),
    .meas_with_temp_out(mwt), .meas_bridge_out(mbo), .meas_temp_out(mto));
  cmr_host_model i_host (.clk_in(clk), .reset_in(rst), .start_in(start), .code_in(code),
    .slow_in(slow), .tx_valid_in(txv), .tx_byte_in(txb), .cmd_valid_out(cmdv),
    .cmd_code_out(cmdc), .tx_ready_out(txr));
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t register read %h expected %h", $time, got, exp);
    end
  endtask
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t stream value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_meas(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t measurement %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_byte(input int idx);
    return (idx < cmr_pkg::MEM_BYTES) ? mem[idx] : cmr_pkg::TRAILER_BYTE;
  endfunction
  function automatic logic [7:0] exp_status(input logic busy, input logic lk, input logic ul);
    return {5'h00, busy, lk, ul};
  endfunction
  function automatic logic [13:0] exp_temp(input logic [1:0] s, input logic [13:0] t);
    return (s != cmr_pkg::OSEL_BRIDGE) ? t : 14'h0000;
  endfunction
  task do_reset;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
  endtask
  task wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdat <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk_reg(rdat, e);
  endtask
  task host_cmd(input logic [15:0] c);
    @(posedge clk);
    start <= 1'b1; code <= c;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task stream;
    i_host.rx_q.delete();
    host_cmd(cmr_pkg::CMD_READ_MEM);
    repeat (9) @(posedge clk);
    rd_reg(5'h13, exp_status(1'b1, 1'b0, 1'b0));
    host_cmd(cmr_pkg::CMD_READ_MEM);
    for (j = 0; j < 100 && i_host.rx_q.size() < 20; j++) @(posedge clk);
    repeat (6) @(posedge clk);
    chk_byte(8'(i_host.rx_q.size()), 8'(cmr_pkg::STREAM_BYTES));
    for (j = 0; j < 20; j++) chk_byte(i_host.rx_q[j], exp_byte(j));
    chk_byte({7'h00, txv}, 8'h00);
  endtask
  task meas(input logic [1:0] s);
    logic [13:0] b, t;
    b = 14'($random(seed));
    t = 14'($random(seed));
    mem[16][4:3] = s;
    wr_reg(5'h10, mem[16]);
    @(posedge clk);
    ms <= 1'b1; bm <= b; tm <= t;
    @(posedge clk);
    ms <= 1'b0;
    #1 chk_meas(16'(mv), 16'h0001);
    chk_meas(16'(mwt), 16'(s != cmr_pkg::OSEL_BRIDGE));
    chk_meas(16'(mbo), 16'(b));
    chk_meas(16'(mto), 16'(exp_temp(s, t)));
  endtask
  initial
  begin
    do_reset;
    for (k = 0; k < 2; k++)
    begin
      lc = k ? 3'h3 : 3'h6;
      do_reset;
      mem[8][7] = lc[0];
      mem[9][1:0] = lc[2:1];
      wr_reg(5'h08, mem[8]);
      wr_reg(5'h09, mem[9]);
      wr_reg(5'h00, 8'h5A);
      rd_reg(5'h00, 8'h00);
      rd_reg(5'h13, exp_status(1'b0, 1'b1, 1'b0));
    end
    host_cmd(cmr_pkg::CMD_UNLOCK);
    wr_reg(5'h00, 8'h5A);
    rd_reg(5'h00, 8'h5A);
    rd_reg(5'h13, exp_status(1'b0, 1'b1, 1'b1));
    do_reset;
    rd_reg(5'h13, exp_status(1'b0, 1'b0, 1'b0));
    for (k = 0; k < 19; k++)
    begin
      mem[k] = 8'($random(seed));
      if (k == 9) mem[k][1:0] = 2'h0;
      wr_reg(5'(k), mem[k]);
    end
    wr_reg(5'h19, 8'hFF);
    for (k = 0; k < 19; k++) rd_reg(5'(k), mem[k]);
    rd_reg(5'h14, 8'h00);
    slow <= 1'b1;
    stream;
    slow <= 1'b0;
    stream;
    for (k = 0; k < 4; k++) meas(2'(k));
    complete_run;
  end
endmodule
`default_nettype wire
